// *** verilog/position_capture_unit.sv ***
// Purpose : position capture on two capture inputs with read port
// Assumes : inputs synchronous to clk_sys; position_in in user units
// Notes   : reads answer one cycle after the request with rd_ack
`timescale 1ns/1ps
module position_capture_unit (
  input  wire logic                            clk_sys,
  input  wire logic                            arst_n,
  input  wire logic                            capture_input_one,
  input  wire logic                            capture_input_two,
  input  wire logic                            arm_one,
  input  wire logic                            arm_two,
  input  wire logic                            disarm_one,
  input  wire logic                            disarm_two,
  input  wire capture_pkg::edge_mode_e         edge_mode_one,
  input  wire capture_pkg::edge_mode_e         edge_mode_two,
  input  wire logic [capture_pkg::POS_W-1:0]   position_in,
  input  wire logic                            shift_valid,
  input  wire logic [capture_pkg::POS_W-1:0]   shift,
  input  wire logic                            rd_req,
  input  wire logic [capture_pkg::ADDR_W-1:0]  rd_addr,
  output logic      [capture_pkg::POS_W-1:0]   rd_data,
  output logic                                 rd_ack,
  output logic                                 rd_err
);
  import capture_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CHAN_N-1:0]            armed;
    logic [CHAN_N-1:0]            captured;
    logic [CHAN_N-1:0][CNT_W-1:0] cnt_event;
    logic [CHAN_N-1:0][CNT_W-1:0] cnt_rise;
    logic [CHAN_N-1:0][CNT_W-1:0] cnt_fall;
    logic [CHAN_N-1:0][POS_W-1:0] pos_cap;
    logic [CHAN_N-1:0][POS_W-1:0] pos_rise;
    logic [CHAN_N-1:0][POS_W-1:0] pos_fall;
    logic [POS_W-1:0]             rd_data;
    logic                         rd_ack;
    logic                         rd_err;
  } unit_state_s;

  unit_state_s st;
  unit_state_s next_st;

  logic [CHAN_N-1:0] sig_in;
  logic [CHAN_N-1:0] arm;
  logic [CHAN_N-1:0] disarm;
  logic [CHAN_N-1:0] rise;
  logic [CHAN_N-1:0] fall;
  logic [CHAN_N-1:0] cap_evt;
  edge_mode_e        mode [CHAN_N];
  logic              lock_read;
  logic [POS_W-1:0]  locked_pos;

  assign sig_in = {capture_input_two, capture_input_one};
  assign arm    = {arm_two, arm_one};
  assign disarm = {disarm_two, disarm_one};
  assign mode[0] = edge_mode_one;
  assign mode[1] = edge_mode_two;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // low four bits of a counter for the summary register
  function automatic logic [NIB_W-1:0] low_nibble(
    input logic [CNT_W-1:0] cnt
  );
    low_nibble = cnt[NIB_W-1:0];
  endfunction

  // counter step: zero on arm, then add one per event, wrapping
  function automatic logic [CNT_W-1:0] count_step(
    input logic [CNT_W-1:0] cnt,
    input logic             clr,
    input logic             inc
  );
    logic [CNT_W-1:0] base;
    base = clr ? CNT_RESET : cnt;
    count_step = inc ? base + CNT_STEP : base;
  endfunction

  // stored position after an optional re-reference shift
  function automatic logic [POS_W-1:0] rebase(
    input logic [POS_W-1:0] pos,
    input logic             en,
    input logic [POS_W-1:0] delta
  );
    rebase = en ? pos + delta : pos;
  endfunction

  // ---------------------------------------------------------------
  // per-input edge detection and capture event selection
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CHAN_N; gi++) begin : g_chan
      capture_edge_detect u_edge (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .sig_in  (sig_in[gi]),
        .rise    (rise[gi]),
        .fall    (fall[gi])
      );

      always_comb begin
        case (mode[gi])
          EDGE_RISING:  cap_evt[gi] = rise[gi];
          EDGE_FALLING: cap_evt[gi] = fall[gi];
          EDGE_BOTH:    cap_evt[gi] = rise[gi] | fall[gi];
          default:      cap_evt[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // consistent pair of input two
  // ---------------------------------------------------------------
  assign lock_read = rd_req && (rd_addr == ADDR_IN2_EVENT_COUNT_LOCK);

  position_lock u_lock (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .lock        (lock_read),
    .cap_pos     (st.pos_cap[1]),
    .shift_valid (shift_valid),
    .shift       (shift),
    .locked_pos  (locked_pos)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;

    for (int i = 0; i < CHAN_N; i++) begin
      // armed window: disarm wins over a simultaneous arm
      if (disarm[i]) begin
        next_st.armed[i] = 1'b0;
      end else if (arm[i]) begin
        next_st.armed[i] = 1'b1;
      end

      // counters only run while the input is armed
      next_st.cnt_event[i] = count_step(st.cnt_event[i], arm[i],
        st.armed[i] & cap_evt[i]);
      next_st.cnt_rise[i] = count_step(st.cnt_rise[i], arm[i],
        st.armed[i] & rise[i]);
      next_st.cnt_fall[i] = count_step(st.cnt_fall[i], arm[i],
        st.armed[i] & fall[i]);

      // status: on a re-arm of an armed input, a capture in the same cycle still sets the flag
      if (st.armed[i] && cap_evt[i]) begin
        next_st.captured[i] = 1'b1;
      end else if (arm[i]) begin
        next_st.captured[i] = 1'b0;
      end

      // stored positions follow the new reference; a capture in
      // the same cycle already sees the new position_in
      next_st.pos_cap[i]  = rebase(st.pos_cap[i], shift_valid,
        shift);
      next_st.pos_rise[i] = rebase(st.pos_rise[i], shift_valid,
        shift);
      next_st.pos_fall[i] = rebase(st.pos_fall[i], shift_valid,
        shift);

      if (st.armed[i] && cap_evt[i]) begin
        next_st.pos_cap[i] = position_in;
      end
      if (st.armed[i] && rise[i]) begin
        next_st.pos_rise[i] = position_in;
      end
      if (st.armed[i] && fall[i]) begin
        next_st.pos_fall[i] = position_in;
      end
    end

    // read port: answer one cycle after the request
    next_st.rd_ack  = rd_req;
    next_st.rd_err  = 1'b0;
    next_st.rd_data = READ_ZERO;
    if (rd_req) begin
      case (rd_addr)
        ADDR_CAPTURE_STATUS: begin
          next_st.rd_data[STATUS_IN1_BIT] = st.captured[0];
          next_st.rd_data[STATUS_IN2_BIT] = st.captured[1];
        end
        ADDR_IN2_CAPTURED_POSITION: begin
          next_st.rd_data = st.pos_cap[1];
        end
        ADDR_IN2_EVENT_COUNT_LOCK: begin
          next_st.rd_data[CNT_W-1:0] = st.cnt_event[1];
        end
        ADDR_IN2_POSITION_LOCK: begin
          next_st.rd_data = locked_pos;
        end
        ADDR_IN2_RISING_POSITION: begin
          next_st.rd_data = st.pos_rise[1];
        end
        ADDR_IN2_FALLING_POSITION: begin
          next_st.rd_data = st.pos_fall[1];
        end
        ADDR_EDGE_COUNTER_SUMMARY: begin
          next_st.rd_data[SUM_IN1_RISE_LO +: NIB_W] =
            low_nibble(st.cnt_rise[0]);
          next_st.rd_data[SUM_IN1_FALL_LO +: NIB_W] =
            low_nibble(st.cnt_fall[0]);
          next_st.rd_data[SUM_IN2_RISE_LO +: NIB_W] =
            low_nibble(st.cnt_rise[1]);
          next_st.rd_data[SUM_IN2_FALL_LO +: NIB_W] =
            low_nibble(st.cnt_fall[1]);
        end
        default: begin
          next_st.rd_err = 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rd_data = st.rd_data;
  assign rd_ack  = st.rd_ack;
  assign rd_err  = st.rd_err;

endmodule

// *** verilog/capture_pkg.sv ***
// Purpose : shared constants and types of the position capture unit
// Assumes : 200 MHz logic clock, register reads over the fieldbus port
// Notes   : register offsets are the printed fieldbus addresses
package capture_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int POS_W   = 32;
  localparam int CNT_W   = 16;
  localparam int ADDR_W  = 16;
  localparam int NIB_W   = 4;
  localparam int CHAN_N  = 2;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_STATUS        = 16'h0A02;
  localparam logic [ADDR_W-1:0] ADDR_IN2_CAPTURED_POSITION = 16'h0A0E;
  localparam logic [ADDR_W-1:0] ADDR_IN2_EVENT_COUNT_LOCK  = 16'h0A32;
  localparam logic [ADDR_W-1:0] ADDR_IN2_POSITION_LOCK     = 16'h0A34;
  localparam logic [ADDR_W-1:0] ADDR_IN2_RISING_POSITION   = 16'h0A4E;
  localparam logic [ADDR_W-1:0] ADDR_IN2_FALLING_POSITION  = 16'h0A50;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_COUNTER_SUMMARY  = 16'h0A5E;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int STATUS_IN1_BIT  = 0;
  localparam int STATUS_IN2_BIT  = 1;
  localparam int SUM_IN1_RISE_LO = 0;
  localparam int SUM_IN1_FALL_LO = 4;
  localparam int SUM_IN2_RISE_LO = 8;
  localparam int SUM_IN2_FALL_LO = 12;

  // ---------------------------------------------------------------
  // reset values and counter step
  // ---------------------------------------------------------------
  localparam logic [POS_W-1:0] POS_RESET  = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RESET  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_STEP   = 16'h0001;
  localparam logic [POS_W-1:0] READ_ZERO  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // capture edge selection of the general captured position
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_RISING  = 2'b00,
    EDGE_FALLING = 2'b01,
    EDGE_BOTH    = 2'b10
  } edge_mode_e;

endpackage

// *** verilog/capture_edge_detect.sv ***
// Purpose : rising and falling edge detector for one capture input
// Assumes : input already synchronous to clk_sys
// Notes   : a level high at reset release reports one rising edge
`timescale 1ns/1ps
module capture_edge_detect (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic sig_in,
  output logic      rise,
  output logic      fall
);
  import capture_pkg::*;

  typedef struct packed {
    logic prev;
  } edge_state_s;

  edge_state_s st;
  edge_state_s next_st;

  always_comb begin
    next_st      = st;
    next_st.prev = sig_in;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = sig_in & ~st.prev;
  assign fall = ~sig_in & st.prev;

endmodule

// *** verilog/position_lock.sv ***
// Purpose : frozen position half of the consistent count/position pair
// Assumes : lock pulses only on a read of the locked event count
// Notes   : follows every re-reference shift while frozen
`timescale 1ns/1ps
module position_lock (
  input  wire logic                           clk_sys,
  input  wire logic                           arst_n,
  input  wire logic                           lock,
  input  wire logic [capture_pkg::POS_W-1:0]  cap_pos,
  input  wire logic                           shift_valid,
  input  wire logic [capture_pkg::POS_W-1:0]  shift,
  output logic      [capture_pkg::POS_W-1:0]  locked_pos
);
  import capture_pkg::*;

  typedef struct packed {
    logic [POS_W-1:0] pos;
  } lock_state_s;

  lock_state_s st;
  lock_state_s next_st;

  always_comb begin
    next_st = st;
    if (lock) begin
      // stored value is still in the old reference this cycle
      next_st.pos = shift_valid ? cap_pos + shift : cap_pos;
    end else if (shift_valid) begin
      next_st.pos = st.pos + shift;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st.pos <= POS_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign locked_pos = st.pos;

endmodule

// *** dv/capture_read_chk.sv ***
// Purpose: read port checks of the position capture unit
// Assumes: one clock domain, reads answered one cycle later
// Notes  : bound to the top module from the bench top file
`timescale 1ns/1ps
module capture_read_chk (
  input wire logic                           clk_sys,
  input wire logic                           arst_n,
  input wire logic                           rd_req,
  input wire logic [capture_pkg::ADDR_W-1:0] rd_addr,
  input wire logic                           shift_valid,
  input wire logic [capture_pkg::POS_W-1:0]  rd_data,
  input wire logic                           rd_ack,
  input wire logic                           rd_err
);
  import capture_pkg::*;
  logic mapped;
  logic narrow;
  assign mapped = rd_addr inside {ADDR_CAPTURE_STATUS,
    ADDR_IN2_CAPTURED_POSITION, ADDR_IN2_EVENT_COUNT_LOCK,
    ADDR_IN2_POSITION_LOCK, ADDR_IN2_RISING_POSITION,
    ADDR_IN2_FALLING_POSITION, ADDR_EDGE_COUNTER_SUMMARY};
  assign narrow = rd_addr inside {ADDR_CAPTURE_STATUS,
    ADDR_IN2_EVENT_COUNT_LOCK, ADDR_EDGE_COUNTER_SUMMARY};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // --------------------------------------------------------------
  // sequences and properties
  // --------------------------------------------------------------
  sequence s_lock_pos_rd;
    rd_req && rd_addr == ADDR_IN2_POSITION_LOCK;
  endsequence
  sequence s_lock_pos_twice;
    (s_lock_pos_rd and !shift_valid) ##1 s_lock_pos_rd;
  endsequence

  property p_ack; rd_req |=> rd_ack; endproperty
  property p_no_ack; !rd_req |=> !rd_ack; endproperty
  property p_err; rd_req && !mapped |=> rd_err && rd_data == 32'h0; endproperty
  property p_no_err; rd_req && mapped |=> !rd_err; endproperty
  property p_idle; !rd_ack |-> rd_data == 32'h0 && !rd_err; endproperty
  property p_narrow; rd_req && narrow |=> rd_data[31:16] == 16'h0; endproperty
  property p_status;
    rd_req && rd_addr == ADDR_CAPTURE_STATUS |=> rd_data[15:2] == 14'h0;
  endproperty
  property p_lock_hold; s_lock_pos_twice |=> $stable(rd_data); endproperty

  a_ack: assert property (p_ack) else $error("read not answered");
  a_no_ack: assert property (p_no_ack) else $error("answer without read");
  a_err: assert property (p_err) else $error("unmapped read not flagged");
  a_no_err: assert property (p_no_err) else $error("mapped read flagged");
  a_idle: assert property (p_idle) else $error("read data outside answer");
  a_narrow: assert property (p_narrow)
    else $error("upper half of narrow register not zero");
  a_status: assert property (p_status)
    else $error("unused status bits set");
  a_lock_hold: assert property (p_lock_hold)
    else $error("locked position moved between reads");
endmodule

// *** dv/capture_trigger.sv ***
// Purpose: far-side trigger source for both capture inputs
// Assumes: levels and position change at falling clock edges only
// Notes  : position moves away one cycle after each edge
`timescale 1ns/1ps
module capture_trigger (
  input  wire logic        clk_sys,
  output logic             capture_input_one,
  output logic             capture_input_two,
  output logic [31:0]      position_in
);
  initial begin
    capture_input_one = 1'b0;
    capture_input_two = 1'b0;
    position_in = 32'h0000_0000;
  end

  task automatic pulse(input int ch, input logic [31:0] p);
    @(negedge clk_sys);
    position_in = p;
    if (ch == 0) begin
      capture_input_one = !capture_input_one;
    end else begin
      capture_input_two = !capture_input_two;
    end
    @(negedge clk_sys);
    position_in = ~p;
    @(negedge clk_sys);
  endtask
endmodule

// *** dv/position_capture_unit_tb.sv ***
// Purpose: self-checking bench of the position capture unit
// Assumes: stimulus at falling edges, fixed random seed
// Notes  : expected values kept in a shadow of every readable counter
`timescale 1ns/1ps
module position_capture_unit_tb;
  import capture_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        arm_one = 1'b0;
  logic        arm_two = 1'b0;
  logic        disarm_one = 1'b0;
  logic        disarm_two = 1'b0;
  logic        shift_valid = 1'b0;
  logic [31:0] shift = 32'h0000_0000;
  logic        rd_req = 1'b0;
  logic [15:0] rd_addr = 16'h0000;
  edge_mode_e  edge_mode_one = EDGE_BOTH;
  edge_mode_e  edge_mode_two = EDGE_RISING;
  logic        capture_input_one;
  logic        capture_input_two;
  logic [31:0] position_in;
  logic [31:0] rd_data;
  logic        rd_ack;
  logic        rd_err;
  logic [15:0] rc [2] = '{16'h0000, 16'h0000};
  logic [15:0] fc [2] = '{16'h0000, 16'h0000};
  logic        lv [2] = '{1'b0, 1'b0};
  logic [15:0] ev2 = 16'h0000;
  logic [31:0] prise = 32'h0;
  logic [31:0] pfall = 32'h0;
  logic [31:0] pcap = 32'h0;
  logic [31:0] plock = 32'h0;
  logic [1:0]  st = 2'h0;
  logic [1:0]  armed = 2'h0;
  int          fail_count = 0;
  int          compares = 0;
  int          seed;

  always #2.5 clk_sys = ~clk_sys;

  capture_trigger trg (.clk_sys(clk_sys),
    .capture_input_one(capture_input_one),
    .capture_input_two(capture_input_two), .position_in(position_in));

  position_capture_unit dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .capture_input_one(capture_input_one),
    .capture_input_two(capture_input_two), .arm_one(arm_one),
    .arm_two(arm_two), .disarm_one(disarm_one), .disarm_two(disarm_two),
    .edge_mode_one(edge_mode_one), .edge_mode_two(edge_mode_two),
    .position_in(position_in), .shift_valid(shift_valid),
    .shift(shift), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_ack(rd_ack), .rd_err(rd_err));

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge clk_sys);
    check({31'h0, rd_ack}, 32'h1);
    check(rd_data, exp);
  endtask

  task automatic idle();
    rd_req = 1'b0;
    @(negedge clk_sys);
  endtask

  function automatic logic hit(input edge_mode_e m, input logic r);
    return m == EDGE_BOTH || (m == EDGE_RISING && r) ||
      (m == EDGE_FALLING && !r);
  endfunction

  function automatic logic [31:0] summary();
    return {16'h0, fc[1][3:0], rc[1][3:0], fc[0][3:0], rc[0][3:0]};
  endfunction

  task automatic toggle(input int ch, input logic [31:0] p);
    logic r;
    r = !lv[ch];
    lv[ch] = r;
    trg.pulse(ch, p);
    if (!armed[ch]) return;
    if (r) rc[ch] += 16'h0001;
    else fc[ch] += 16'h0001;
    if (ch == 1 && r) prise = p;
    if (ch == 1 && !r) pfall = p;
    if (hit(ch == 0 ? edge_mode_one : edge_mode_two, r)) begin
      st[ch] = 1'b1;
      if (ch == 1) ev2 += 16'h0001;
      if (ch == 1) pcap = p;
    end
  endtask

  task automatic arm(input int ch, input edge_mode_e m);
    if (ch == 0) begin
      arm_one = 1'b1;
      edge_mode_one = m;
    end else begin
      arm_two = 1'b1;
      edge_mode_two = m;
    end
    @(negedge clk_sys);
    if (ch == 0) arm_one = 1'b0;
    else arm_two = 1'b0;
    armed[ch] = 1'b1;
    rc[ch] = 16'h0000;
    fc[ch] = 16'h0000;
    st[ch] = 1'b0;
    if (ch == 1) ev2 = 16'h0000;
  endtask

  task automatic move(input logic [31:0] dv);
    shift_valid = 1'b1;
    shift = dv;
    @(negedge clk_sys);
    shift_valid = 1'b0;
    prise += dv;
    pfall += dv;
    pcap += dv;
    plock += dv;
  endtask

  task automatic check_all();
    plock = pcap;
    rd(ADDR_CAPTURE_STATUS, {30'h0, st});
    rd(ADDR_EDGE_COUNTER_SUMMARY, summary());
    rd(ADDR_IN2_CAPTURED_POSITION, pcap);
    rd(ADDR_IN2_RISING_POSITION, prise);
    rd(ADDR_IN2_FALLING_POSITION, pfall);
    rd(ADDR_IN2_EVENT_COUNT_LOCK, {16'h0, ev2});
    rd(ADDR_IN2_POSITION_LOCK, plock);
    idle();
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    seed = $urandom(32'h29D4);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    arm(0, EDGE_BOTH);
    for (int m = 0; m < 4; m++) begin
      arm(0, edge_mode_e'(3 - m));
      arm(1, edge_mode_e'(m));
      repeat (40) toggle(int'($urandom_range(1, 0)), $urandom);
      toggle(1, 32'h8000_0000);
      toggle(1, 32'h7FFF_FFFF);
      check_all();
      $display("edge mode test %0d done", m);
    end
    arm(1, EDGE_BOTH);
    toggle(1, $urandom);
    rd(ADDR_IN2_EVENT_COUNT_LOCK, {16'h0, ev2});
    idle();
    plock = pcap;
    toggle(1, $urandom);
    toggle(1, $urandom);
    move($urandom);
    rd(ADDR_IN2_POSITION_LOCK, plock);
    rd(ADDR_IN2_POSITION_LOCK, plock);
    idle();
    check_all();
    $display("lock and shift test done");
    rd(16'h0A04, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    idle();
    $display("unmapped read test done");
    disarm_one = 1'b1;
    disarm_two = 1'b1;
    @(negedge clk_sys);
    disarm_one = 1'b0;
    disarm_two = 1'b0;
    armed = 2'b00;
    toggle(0, $urandom);
    toggle(1, $urandom);
    check_all();
    $display("disarm test done");
    arst_n = 1'b0;
    @(negedge clk_sys);
    arst_n = 1'b1;
    rd(ADDR_CAPTURE_STATUS, 32'h0);
    rd(ADDR_EDGE_COUNTER_SUMMARY, 32'h0);
    rd(ADDR_IN2_CAPTURED_POSITION, 32'h0);
    rd(ADDR_IN2_POSITION_LOCK, 32'h0);
    idle();
    $display("reset test done");
    finish_test();
  end

  initial begin
    #(5 * 20000);
    fail_count++;
    finish_test();
  end
endmodule

bind position_capture_unit capture_read_chk chk (.clk_sys(clk_sys),
  .arst_n(arst_n), .rd_req(rd_req), .rd_addr(rd_addr),
  .shift_valid(shift_valid), .rd_data(rd_data), .rd_ack(rd_ack),
  .rd_err(rd_err));
